// ===== rtl/cfg_header_defines.vh
/*
 configuration header constants: dword offsets, field layouts, reset values.
 assumes inclusion by bare name from the header register module.
*/
`ifndef CFG_HEADER_DEFINES_VH
`define CFG_HEADER_DEFINES_VH

// dword offsets (byte address of each aligned dword)
`define OFS_IDENT 8'h00
`define OFS_CMD_STAT 8'h04
`define OFS_CLASS_REV 8'h08
`define OFS_MISC 8'h0c
`define OFS_SOCK_BASE 8'h10
`define OFS_CAP_SEC 8'h14
`define OFS_BUSNUM 8'h18
`define OFS_MEM0_BASE 8'h1c
`define OFS_MEM0_LIMIT 8'h20
`define OFS_INTR_BRIDGE 8'h3c
`define OFS_SUBSYS 8'h40
`define OFS_LEGACY 8'h44
`define OFS_SYSCTL 8'h80
`define OFS_MFROUTE 8'h8c
`define OFS_RETRY_CARD 8'h90
`define OFS_XFER0 8'h94
`define OFS_XFER1 8'h98
`define OFS_PWR_CAP 8'ha0
`define OFS_PWR_CSR 8'ha4
`define OFS_GPE 8'ha8
`define OFS_GPIO 8'hac
`define OFS_SERIAL 8'hb0

// command field: writable bits 8,6,5,2,1,0
`define CMD_WMASK 16'h0167
`define CMD_RESET 16'h0000
// status field: clear-on-one bits 15..11 and 8
`define STAT_CMASK 16'hf900
`define STAT_RESET 16'h0210
// secondary_bus_status uses the same clear-on-one layout
`define SEC_STAT_CMASK 16'hf900
`define SEC_STAT_RESET 16'h0000
// general-purpose event status bits, clear-on-one
`define GPE_STAT_CMASK 16'h891f

// fixed read-only values
`define HEADER_TYPE_VAL 8'h02
`define CLASS_CODE_VAL 24'h060700
`define INTR_PIN_VAL 8'h01
`define CAP_PTR_VAL 8'ha0
`define PWR_CAP_ID_VAL 8'h01
`define PWR_CAP_NEXT_VAL 8'h00
`define PWR_CAP_VAL 16'h0000

`endif

// ===== rtl/cfg_header_regs.v
/*
 configuration header register bank of a pc card bridge function.
 assumes a single-cycle config access port: cfg_wr/cfg_rd strobes with a
 dword address, byte enables and data, all synchronous to clk.
*/
`timescale 1ns/10ps
`include "cfg_header_defines.vh"

module cfg_header_regs #(
	parameter [15:0] MAKER_ID = 16'h1234,
	parameter [15:0] PART_ID = 16'h5678,
	parameter [7:0] REVISION = 8'h01
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// configuration access
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	output reg cfg_rvalid,
	// hardware event inputs
	input wire [15:0] stat_event,
	input wire [15:0] sec_stat_event,
	input wire [15:0] gpe_event,
	input wire [15:0] gp_input_pins,
	input wire serial_done_event,
	// control outputs
	output wire [15:0] cmd_out,
	output wire [31:0] socket_base_out,
	output wire [15:0] gp_output_pins
);
// MAKER_ID, PART_ID, REVISION values are arbitrary

	reg [15:0] cmd_r;
	reg [15:0] stat_r;
	reg [7:0] cls_r;
	reg [7:0] lat_r;
	reg [7:0] builtin_self_test_r;
	reg [31:0] sock_base_r;
	reg [15:0] sec_stat_r;
	reg [31:0] busnum_r;
	reg [31:0] mem0_base_r;
	reg [31:0] mem0_limit_r;
	reg [7:0] intr_line_r;
	reg [15:0] bridge_ctl_r;
	reg [31:0] subsys_r;
	reg [31:0] legacy_r;
	reg [31:0] sysctl_r;
	reg [31:0] mfroute_r;
	reg [31:0] retry_card_r;
	reg [31:0] xfer0_r;
	reg [31:0] xfer1_r;
	reg [15:0] pwr_csr_r;
	reg [15:0] gpe_stat_r;
	reg [15:0] gpe_en_r;
	reg [15:0] gp_in_r;
	reg [15:0] gp_out_r;
	reg [31:0] serial_r;
	reg serial_done_r;
	reg [31:0] rdata_nxt;
	wire [31:0] bmask;

	assign bmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
	assign cmd_out = cmd_r;
	assign socket_base_out = sock_base_r;
	assign gp_output_pins = gp_out_r;

////////////////////////////////////////////////////////////////////////////////
// write merge helpers

	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] wd;
		input [31:0] m;
		begin
			wmerge = (old & ~m) | (wd & m);
		end
	endfunction

	function [15:0] wmerge16;
		input [15:0] old;
		input [15:0] wd;
		input [15:0] m;
		begin
			wmerge16 = (old & ~m) | (wd & m);
		end
	endfunction

	// clear on one, hardware set wins over clear
	function [15:0] w1c;
		input [15:0] old;
		input [15:0] wd;
		input [15:0] m;
		input [15:0] ev;
		begin
			w1c = (old & ~(wd & m)) | ev;
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////
// register writes

	always @(posedge clk) begin
		if (!resetn) begin
			cmd_r <= `CMD_RESET;
			stat_r <= `STAT_RESET;
			cls_r <= 8'h00;
			lat_r <= 8'h00;
			builtin_self_test_r <= 8'h00;
			sock_base_r <= 32'h00000000;
			sec_stat_r <= `SEC_STAT_RESET;
			busnum_r <= 32'h00000000;
			mem0_base_r <= 32'h00000000;
			mem0_limit_r <= 32'h00000000;
			intr_line_r <= 8'h00;
			bridge_ctl_r <= 16'h0000;
			subsys_r <= 32'h00000000;
			legacy_r <= 32'h00000000;
			sysctl_r <= 32'h00000000;
			mfroute_r <= 32'h00000000;
			retry_card_r <= 32'h00000000;
			xfer0_r <= 32'h00000000;
			xfer1_r <= 32'h00000000;
			pwr_csr_r <= 16'h0000;
			gpe_stat_r <= 16'h0000;
			gpe_en_r <= 16'h0000;
			gp_in_r <= 16'h0000;
			gp_out_r <= 16'h0000;
			serial_r <= 32'h00000000;
			serial_done_r <= 1'b0;
		end else begin
			// autonomous hardware updates
			gp_in_r <= gp_input_pins;
			stat_r <= stat_r | (stat_event & `STAT_CMASK);
			sec_stat_r <= sec_stat_r | (sec_stat_event & `SEC_STAT_CMASK);
			gpe_stat_r <= gpe_stat_r | (gpe_event & `GPE_STAT_CMASK);
			// serial done flag clears on read, a new event wins
			if (serial_done_event) begin
				serial_done_r <= 1'b1;
			end else if (cfg_rd && cfg_addr == `OFS_SERIAL && cfg_be[3]) begin
				serial_done_r <= 1'b0;
			end
			if (cfg_wr) begin
				// identifier dword and reserved offsets take no write
				if (cfg_addr == `OFS_CMD_STAT) begin
					cmd_r <= wmerge16(cmd_r, cfg_wdata[15:0], bmask[15:0] & `CMD_WMASK);
					stat_r <= w1c(stat_r, cfg_wdata[31:16], bmask[31:16] & `STAT_CMASK,
						stat_event & `STAT_CMASK);
				end else if (cfg_addr == `OFS_MISC) begin
					if (cfg_be[0]) cls_r <= cfg_wdata[7:0];
					if (cfg_be[1]) lat_r <= cfg_wdata[15:8];
					// self-test start bit 6 is set by a write of one
					if (cfg_be[3] && cfg_wdata[30]) builtin_self_test_r <= builtin_self_test_r | 8'h40;
				end else if (cfg_addr == `OFS_SOCK_BASE) begin
					sock_base_r <= wmerge(sock_base_r, cfg_wdata, bmask & 32'hfffff000);
				end else if (cfg_addr == `OFS_CAP_SEC) begin
					sec_stat_r <= w1c(sec_stat_r, cfg_wdata[31:16],
						bmask[31:16] & `SEC_STAT_CMASK, sec_stat_event & `SEC_STAT_CMASK);
				end else if (cfg_addr == `OFS_BUSNUM) begin
					busnum_r <= wmerge(busnum_r, cfg_wdata, bmask);
				end else if (cfg_addr == `OFS_MEM0_BASE) begin
					mem0_base_r <= wmerge(mem0_base_r, cfg_wdata, bmask & 32'hfffff000);
				end else if (cfg_addr == `OFS_MEM0_LIMIT) begin
					mem0_limit_r <= wmerge(mem0_limit_r, cfg_wdata, bmask & 32'hfffff000);
				end else if (cfg_addr == `OFS_INTR_BRIDGE) begin
					if (cfg_be[0]) intr_line_r <= cfg_wdata[7:0];
					bridge_ctl_r <= wmerge16(bridge_ctl_r, cfg_wdata[31:16], bmask[31:16]);
				end else if (cfg_addr == `OFS_SUBSYS) begin
					subsys_r <= wmerge(subsys_r, cfg_wdata, bmask);
				end else if (cfg_addr == `OFS_LEGACY) begin
					legacy_r <= wmerge(legacy_r, cfg_wdata, bmask & 32'hfffffffe);
				end else if (cfg_addr == `OFS_SYSCTL) begin
					sysctl_r <= wmerge(sysctl_r, cfg_wdata, bmask);
				end else if (cfg_addr == `OFS_MFROUTE) begin
					mfroute_r <= wmerge(mfroute_r, cfg_wdata, bmask & 32'h0fffffff);
				end else if (cfg_addr == `OFS_RETRY_CARD) begin
					retry_card_r <= wmerge(retry_card_r, cfg_wdata, bmask);
				end else if (cfg_addr == `OFS_XFER0) begin
					xfer0_r <= wmerge(xfer0_r, cfg_wdata, bmask);
				end else if (cfg_addr == `OFS_XFER1) begin
					xfer1_r <= wmerge(xfer1_r, cfg_wdata, bmask);
				end else if (cfg_addr == `OFS_PWR_CSR) begin
					pwr_csr_r <= wmerge16(pwr_csr_r, cfg_wdata[15:0], bmask[15:0] & 16'h0103);
				end else if (cfg_addr == `OFS_GPE) begin
					gpe_stat_r <= w1c(gpe_stat_r, cfg_wdata[15:0],
						bmask[15:0] & `GPE_STAT_CMASK, gpe_event & `GPE_STAT_CMASK);
					gpe_en_r <= wmerge16(gpe_en_r, cfg_wdata[31:16], bmask[31:16]);
				end else if (cfg_addr == `OFS_GPIO) begin
					gp_out_r <= wmerge16(gp_out_r, cfg_wdata[31:16], bmask[31:16]);
				end else if (cfg_addr == `OFS_SERIAL) begin
					serial_r <= wmerge(serial_r, cfg_wdata, bmask & 32'h7fffffff);
				end
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// read decode

	always @* begin
		rdata_nxt = 32'h00000000;
		if (cfg_addr == `OFS_IDENT) begin
			rdata_nxt = {PART_ID, MAKER_ID};
		end else if (cfg_addr == `OFS_CMD_STAT) begin
			rdata_nxt = {stat_r, cmd_r};
		end else if (cfg_addr == `OFS_CLASS_REV) begin
			rdata_nxt = {`CLASS_CODE_VAL, REVISION};
		end else if (cfg_addr == `OFS_MISC) begin
			rdata_nxt = {builtin_self_test_r, `HEADER_TYPE_VAL, lat_r, cls_r};
		end else if (cfg_addr == `OFS_SOCK_BASE) begin
			rdata_nxt = sock_base_r;
		end else if (cfg_addr == `OFS_CAP_SEC) begin
			rdata_nxt = {sec_stat_r, 8'h00, `CAP_PTR_VAL};
		end else if (cfg_addr == `OFS_BUSNUM) begin
			rdata_nxt = busnum_r;
		end else if (cfg_addr == `OFS_MEM0_BASE) begin
			rdata_nxt = mem0_base_r;
		end else if (cfg_addr == `OFS_MEM0_LIMIT) begin
			rdata_nxt = mem0_limit_r;
		end else if (cfg_addr == `OFS_INTR_BRIDGE) begin
			rdata_nxt = {bridge_ctl_r, `INTR_PIN_VAL, intr_line_r};
		end else if (cfg_addr == `OFS_SUBSYS) begin
			rdata_nxt = subsys_r;
		end else if (cfg_addr == `OFS_LEGACY) begin
			rdata_nxt = legacy_r | 32'h00000001;
		end else if (cfg_addr == `OFS_SYSCTL) begin
			rdata_nxt = sysctl_r;
		end else if (cfg_addr == `OFS_MFROUTE) begin
			rdata_nxt = mfroute_r;
		end else if (cfg_addr == `OFS_RETRY_CARD) begin
			rdata_nxt = retry_card_r;
		end else if (cfg_addr == `OFS_XFER0) begin
			rdata_nxt = xfer0_r;
		end else if (cfg_addr == `OFS_XFER1) begin
			rdata_nxt = xfer1_r;
		end else if (cfg_addr == `OFS_PWR_CAP) begin
			rdata_nxt = {`PWR_CAP_VAL, `PWR_CAP_NEXT_VAL, `PWR_CAP_ID_VAL};
		end else if (cfg_addr == `OFS_PWR_CSR) begin
			rdata_nxt = {16'h0000, pwr_csr_r};
		end else if (cfg_addr == `OFS_GPE) begin
			rdata_nxt = {gpe_en_r, gpe_stat_r};
		end else if (cfg_addr == `OFS_GPIO) begin
			rdata_nxt = {gp_out_r, gp_in_r};
		end else if (cfg_addr == `OFS_SERIAL) begin
			rdata_nxt = {serial_done_r, serial_r[30:0]};
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			cfg_rdata <= 32'h00000000;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= rdata_nxt;
			end
		end
	end

endmodule

// ===== verif/cfg_header_sva.sv
/*
 checker for the config header bank: read answer timing, fixed fields, writes.
 assumes binding to cfg_header_regs with its parameters handed on.
*/
`timescale 1ns/10ps
`include "cfg_header_defines.vh"
module cfg_header_sva #(
	parameter [15:0] MAKER_ID = 16'h1234,
	parameter [15:0] PART_ID = 16'h5678,
	parameter [7:0] REVISION = 8'h01
) (
	// clock and reset
	input wire clk,
	input wire resetn,
	// access port
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire cfg_rvalid,
	// side signals
	input wire [15:0] gp_input_pins,
	input wire [15:0] cmd_out
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
////////////////////////////////////////////////////////////////
chk_rvalid_pulse: assert property (cfg_rd |=> cfg_rvalid)
	else $error("read not answered");
chk_rvalid_quiet: assert property (!cfg_rd |=> !cfg_rvalid)
	else $error("answer without read");
chk_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata))
	else $error("read data moved");
chk_ident_read: assert property (cfg_rd && cfg_addr == 8'h00 && cfg_be == 4'hf
	|=> cfg_rdata == {PART_ID, MAKER_ID}) else $error("ident wrong");
chk_class_read: assert property (cfg_rd && cfg_addr == 8'h08 && cfg_be == 4'hf
	|=> cfg_rdata == {`CLASS_CODE_VAL, REVISION}) else $error("class wrong");
chk_hdr_type: assert property (cfg_rd && cfg_addr == 8'h0c && cfg_be[2]
	|=> cfg_rdata[23:16] == `HEADER_TYPE_VAL) else $error("header type wrong");
chk_rsvd_zero: assert property (cfg_rd && cfg_addr inside {8'h48, 8'h7c, 8'h84, 8'h9c}
	|=> cfg_rdata == 32'h0) else $error("reserved not zero");
chk_cmd_write: assert property (cfg_wr && cfg_addr == 8'h04 && cfg_be[1:0] == 2'b11
	|=> {16'h0, cmd_out} == ($past(cfg_wdata) & {16'h0, `CMD_WMASK})) else $error("cmd write");
chk_cmd_hold: assert property (!(cfg_wr && cfg_addr == 8'h04) |=> $stable(cmd_out))
	else $error("cmd moved");
chk_gp_sample: assert property (cfg_rd && cfg_addr == 8'hac && cfg_be[1:0] == 2'b11
	&& $past(resetn) && $past(resetn, 2) && $stable(gp_input_pins)
	&& gp_input_pins == $past(gp_input_pins, 2)
	|=> cfg_rdata[15:0] == $past(gp_input_pins)) else $error("gp input wrong");
endmodule
bind cfg_header_regs cfg_header_sva #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID),
	.REVISION(REVISION)) i_cfg_header_sva (.clk(clk), .resetn(resetn), .cfg_wr(cfg_wr),
	.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
	.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .gp_input_pins(gp_input_pins),
	.cmd_out(cmd_out));

// ===== verif/cfg_host.sv
/*
 config host model: single write and read cycles on the access port.
 assumes the caller has released reset; signals move just after clk rises.
*/
`timescale 1ns/10ps
module cfg_host (
	// clock
	input wire clk,
	// requests
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	// answer
	input wire [31:0] cfg_rdata,
	input wire cfg_rvalid
);
initial {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = 46'h0;
// released address and data lines show inverted values, not the last ones; byte enables go to zero
task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
	@(posedge clk);
	{cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, b, d};
	@(posedge clk);
	{cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b0, ~a, 4'h0, ~d};
endtask
task rd(input logic [7:0] a, input logic [3:0] b, output logic [31:0] q);
	@(posedge clk);
	{cfg_rd, cfg_addr, cfg_be} <= {1'b1, a, b};
	@(posedge clk);
	{cfg_rd, cfg_addr, cfg_be} <= {1'b0, ~a, 4'h0};
	#1;
	q = cfg_rvalid ? cfg_rdata : ~cfg_rdata;
endtask
endmodule

// ===== verif/testbench.sv
/*
 testbench for the config header bank: table of write/read rows, then events.
 assumes the host model drives the access port; events come from here.
*/
`timescale 1ns/10ps
`include "cfg_header_defines.vh"
module testbench;
// arbitrary identity codes
localparam [15:0] MK = 16'h2c3d;
localparam [15:0] PT = 16'h7e19;
localparam [7:0] REV = 8'h05;
// clock, reset, events
logic clk = 1'b0;
logic resetn = 1'b0;
logic [15:0] stat_event = 16'h0;
logic [15:0] gp_input_pins = 16'h0;
logic [15:0] gpe_event = 16'h0;
logic serial_done_event = 1'b0;
wire cfg_wr, cfg_rd, cfg_rvalid;
wire [7:0] cfg_addr;
wire [3:0] cfg_be;
wire [31:0] cfg_wdata, cfg_rdata, socket_base_out;
wire [15:0] cmd_out, gp_output_pins;
int num_errors = 0;
int cmp_count = 0;
logic [31:0] q;
typedef struct packed {logic [7:0] a; logic [3:0] b; logic [31:0] d, m, e;} row_t;
row_t rows [0:9] = '{
	'{8'h00, 4'hf, 32'hffffffff, 32'hffffffff, {PT, MK}},
	'{8'h04, 4'hf, 32'hffffffff, 32'hffffffff, {`STAT_RESET, `CMD_WMASK}},
	'{8'h08, 4'hf, 32'hffffffff, 32'hffffffff, {`CLASS_CODE_VAL, REV}},
	'{8'h18, 4'hf, 32'h12345678, 32'hffffffff, 32'h12345678},
	'{8'h1c, 4'hf, 32'hffffffff, 32'hfffff000, 32'hfffff000},
	'{8'h20, 4'hf, 32'ha5a5a5a5, 32'hfffff000, 32'ha5a5a000},
	'{8'h3c, 4'h1, 32'h000000a5, 32'h0000ffff, {16'h0, `INTR_PIN_VAL, 8'ha5}},
	'{8'h48, 4'hf, 32'hffffffff, 32'hffffffff, 32'h0},
	'{8'h9c, 4'hf, 32'hffffffff, 32'hffffffff, 32'h0},
	'{8'ha0, 4'hf, 32'hffffffff, 32'hffffffff,
		{`PWR_CAP_VAL, `PWR_CAP_NEXT_VAL, `PWR_CAP_ID_VAL}}};
always #50 clk = ~clk;
cfg_header_regs #(.MAKER_ID(MK), .PART_ID(PT), .REVISION(REV)) i_cfg_header_regs (
	.clk(clk), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
	.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
	.stat_event(stat_event), .sec_stat_event(16'h0), .gpe_event(gpe_event),
	.gp_input_pins(gp_input_pins), .serial_done_event(serial_done_event),
	.cmd_out(cmd_out), .socket_base_out(socket_base_out), .gp_output_pins(gp_output_pins));
cfg_host i_cfg_host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
	.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
////////////////////////////////////////////////////////////////
task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
	cmp_count++;
	if (g !== e) begin
		num_errors++;
		$display("CHECK FAILED %s expected %h seen %h", n, e, g);
	end
endtask
task print_verdict;
	$display("errors %0d compares %0d", num_errors, cmp_count);
	if (num_errors == 0 && cmp_count > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
task reset_dut;
	@(posedge clk) resetn <= 1'b0;
	repeat (5) @(posedge clk);
	resetn <= 1'b1;
endtask
initial begin
	repeat (3000) @(posedge clk);
	num_errors++;
	print_verdict;
end
initial begin
	reset_dut;
	foreach (rows[i]) begin
		i_cfg_host.wr(rows[i].a, rows[i].b, rows[i].d);
		i_cfg_host.rd(rows[i].a, 4'hf, q);
		cmp($sformatf("row %0d", i), rows[i].e, q & rows[i].m);
	end
	// status flag: set by hardware, kept on write 0, cleared on write 1
	@(posedge clk) stat_event <= 16'h8000;
	@(posedge clk) stat_event <= 16'h0;
	i_cfg_host.wr(8'h04, 4'hc, 32'h0);
	i_cfg_host.rd(8'h04, 4'hc, q);
	cmp("status set", 32'h1, {31'h0, q[31]});
	i_cfg_host.wr(8'h04, 4'hc, 32'h80000000);
	i_cfg_host.rd(8'h04, 4'hc, q);
	cmp("status clear", 32'h0, {31'h0, q[31]});
	// hardware set in the same cycle as a write-one-clear wins
	fork
		i_cfg_host.wr(8'h04, 4'hc, 32'h08000000);
		begin
			@(posedge clk) stat_event <= 16'h0800;
			@(posedge clk) stat_event <= 16'h0;
		end
	join
	i_cfg_host.rd(8'h04, 4'hc, q);
	cmp("status set wins", 32'h1, {31'h0, q[27]});
	i_cfg_host.wr(8'h04, 4'hc, 32'h08000000);
	i_cfg_host.rd(8'h04, 4'hc, q);
	cmp("status clear 11", 32'h0, {31'h0, q[27]});
	// event status: set by hardware, cleared by write 1; enable half writable
	@(posedge clk) gpe_event <= 16'h0001;
	@(posedge clk) gpe_event <= 16'h0;
	i_cfg_host.wr(8'ha8, 4'hc, 32'h89000000);
	i_cfg_host.rd(8'ha8, 4'hf, q);
	cmp("event set", 32'h89000001, q);
	i_cfg_host.wr(8'ha8, 4'h3, 32'h00000001);
	i_cfg_host.rd(8'ha8, 4'hf, q);
	cmp("event clear", 32'h89000000, q);
	// control outputs follow their registers
	i_cfg_host.wr(8'hac, 4'hc, 32'h5a5a0000);
	#1;
	cmp("gp out", 32'h5a5a, {16'h0, gp_output_pins});
	i_cfg_host.wr(8'h10, 4'hf, 32'hffffffff);
	#1;
	cmp("socket base", 32'hfffff000, socket_base_out);
	// self-test start bit: set by write 1, kept on write 0
	i_cfg_host.wr(8'h0c, 4'h8, 32'h40000000);
	i_cfg_host.wr(8'h0c, 4'h8, 32'h0);
	i_cfg_host.rd(8'h0c, 4'h8, q);
	cmp("self-test set", 32'h1, {31'h0, q[30]});
	// serial done flag clears on read
	@(posedge clk) serial_done_event <= 1'b1;
	@(posedge clk) serial_done_event <= 1'b0;
	i_cfg_host.rd(8'hb0, 4'h8, q);
	cmp("done first read", 32'h1, {31'h0, q[31]});
	i_cfg_host.rd(8'hb0, 4'h8, q);
	cmp("done second read", 32'h0, {31'h0, q[31]});
	// input pins follow the outside world
	@(posedge clk) gp_input_pins <= 16'hc3a5;
	repeat (3) @(posedge clk);
	i_cfg_host.rd(8'hac, 4'h3, q);
	cmp("gp input", 32'hc3a5, {16'h0, q[15:0]});
	// second reset in mid-run
	i_cfg_host.wr(8'h04, 4'h3, 32'hffff);
	reset_dut;
	#1;
	cmp("cmd after reset", 32'h0, {16'h0, cmd_out});
	cmp("base after reset", 32'h0, socket_base_out);
	cmp("gp out after reset", 32'h0, {16'h0, gp_output_pins});
	i_cfg_host.rd(8'h04, 4'hf, q);
	cmp("status reset", {`STAT_RESET, `CMD_RESET}, q);
	print_verdict;
end
endmodule
